// *** design/crb_map.vh ***
// constants for the conditional relative branch unit
`ifndef CRB_MAP_VH
`define CRB_MAP_VH
// opcode low-bit patterns (displacement or bit-select sits above them)
`define CRB_OP_CC_MASK    8'h07
`define CRB_OP_CARRY_CLR  8'h02
`define CRB_OP_ZERO_CLR   8'h00
`define CRB_OP_BIT_MASK   8'h1f
`define CRB_OP_BIT_LOW    8'h03
`define CRB_OP_BIT_HIGH   8'h13
// displacement bias: field value minus bias is the signed jump
`define CRB_DISP5_BIAS    8'h0f
`define CRB_DISP8_BIAS    8'h7e
// field positions
`define CRB_DISP5_LSB     3
`define CRB_BITSEL_LSB    5
// instruction lengths in bytes and cycles
`define CRB_SHORT_BYTES   2'h1
`define CRB_SHORT_CYCLES  3'h2
`define CRB_LONG_BYTES    2'h3
`define CRB_LONG_CYCLES   3'h5
// pc width and reset value
`define CRB_PC_W          12
`define CRB_PC_RESET      12'h000
`endif

// *** design/crb_target.v ***
// branch target adder shared by both branch forms
`timescale 1ns/1ps
`include "crb_map.vh"
module crb_target #(
  parameter PC_W = `CRB_PC_W
) (
  input  wire [PC_W-1:0] base,
  input  wire [7:0]      disp,
  input  wire            short_form,
  output wire [PC_W-1:0] target
);
  // short form: 5-bit field, value e-15 gives -15..+16
  // long form: byte, value ee-126 gives -126..+129
  wire [PC_W-1:0] d5;
  wire [PC_W-1:0] d8;
  wire [PC_W-1:0] offs;
  assign d5     = {{(PC_W-5){1'b0}}, disp[4:0]}
                  - {{(PC_W-8){1'b0}}, `CRB_DISP5_BIAS};
  assign d8     = {{(PC_W-8){1'b0}}, disp}
                  - {{(PC_W-8){1'b0}}, `CRB_DISP8_BIAS};
  assign offs   = short_form ? d5 : d8;
  assign target = base + offs;
endmodule

// *** design/crb_branch_unit.v ***
// conditional relative branch execution unit
// Behaviour
// RQ1: carry-clear short branch jumps when carry is 0; flags untouched.
// RQ2: zero-clear short branch jumps when zero is 0; flags untouched.
// RQ3: short branches are one byte, two cycles, reach -15 to +16.
// RQ4: bit-low branch jumps when selected data-space bit is 0.
// RQ5: bit-high branch jumps when selected data-space bit is 1.
// RQ6: bit branches reach -126 to +129 from an 8-bit displacement.
// RQ7: bit branches copy tested bit into carry; zero kept.
// RQ8: bit branches are three bytes, five cycles: opcode, address, disp.
// RQ9: program counter is twelve bits wide.
// RQ10: displacement adds to address of the next instruction, all four.
`timescale 1ns/1ps
`include "crb_map.vh"
module crb_branch_unit #(
  parameter PC_W = `CRB_PC_W
) (
  input  wire            clk,
  input  wire            reset_n,
  input  wire            clk_en,
  input  wire            issue,
  input  wire [7:0]      opcode,
  input  wire [7:0]      addr_byte,
  input  wire [7:0]      disp_byte,
  input  wire [PC_W-1:0] pc_in,
  input  wire            carry_in,
  input  wire            zero_in,
  input  wire [7:0]      data_value,
  input  wire            data_valid,
  output wire            busy,
  output wire            is_branch,
  output wire [7:0]      data_addr,
  output wire            data_req,
  output reg             done_ff,
  output reg  [PC_W-1:0] pc_out_ff,
  output reg             carry_out_ff,
  output reg             zero_out_ff,
  output reg             taken_ff,
  output reg  [1:0]      bytes_ff,
  output reg  [2:0]      cycles_ff
);
  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  // release lands on a clock edge so every flop leaves reset together
  reg rst_meta_ff;
  reg rst_sync_ff;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // pure decode of the first byte, so the caller may test is_branch early
  wire br_carry_clr;
  wire br_zero_clr;
  wire br_bit_low;
  wire br_bit_high;
  wire long_form;
  assign br_carry_clr = (opcode & `CRB_OP_CC_MASK) == `CRB_OP_CARRY_CLR;
  assign br_zero_clr  = (opcode & `CRB_OP_CC_MASK) == `CRB_OP_ZERO_CLR;
  assign br_bit_low   = (opcode & `CRB_OP_BIT_MASK) == `CRB_OP_BIT_LOW;
  assign br_bit_high  = (opcode & `CRB_OP_BIT_MASK) == `CRB_OP_BIT_HIGH;
  assign long_form    = br_bit_low | br_bit_high;
  assign is_branch    = br_carry_clr | br_zero_clr | long_form;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_READ = 2'h2;

  // wait preloads: issue and done cycles count towards the total, and
  // the long form spends one more cycle on the data-space read
  localparam [2:0] SHORT_WAIT = `CRB_SHORT_CYCLES - 3'h2;
  localparam [2:0] LONG_WAIT  = `CRB_LONG_CYCLES - 3'h3;

  reg [1:0]      state_ff;
  reg [2:0]      cnt_ff;
  reg            bit_low_ff;
  reg [2:0]      bitsel_ff;
  reg [7:0]      addr_ff;
  reg [7:0]      disp_ff;
  reg [PC_W-1:0] base_ff;
  reg            cond_ff;
  reg            tested_ff;
  reg            short_ff;

  wire [PC_W-1:0] target;
  wire [PC_W-1:0] base_now;
  wire            tested_bit;
  wire            short_cond;

  // next-instruction address is the reference for every form
  assign base_now   = pc_in + {{(PC_W-2){1'b0}},
                      (long_form ? `CRB_LONG_BYTES : `CRB_SHORT_BYTES)}; //RQ10
  // bit select is held in a register so the read may answer late
  assign tested_bit = data_value[bitsel_ff];
  assign short_cond = br_carry_clr ? ~carry_in : ~zero_in; //RQ1 //RQ2
  // busy falls in the done cycle, so the next issue may follow at once
  assign busy       = state_ff != ST_IDLE;
  assign data_req   = state_ff == ST_READ;
  assign data_addr  = addr_ff;

  // ----------------------------------------------------------------
  // target adder
  // ----------------------------------------------------------------
  // operands are registered, which keeps the adder off the issue path
  crb_target #(
    .PC_W       (PC_W)
  ) u_target (
    .base       (base_ff),
    .disp       (disp_ff),
    .short_form (short_ff),
    .target     (target)
  );

  always @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 3'h0;
      bit_low_ff   <= 1'b0;
      bitsel_ff    <= 3'h0;
      addr_ff      <= 8'h00;
      disp_ff      <= 8'h00;
      base_ff      <= `CRB_PC_RESET;
      cond_ff      <= 1'b0;
      tested_ff    <= 1'b0;
      short_ff     <= 1'b1;
      done_ff      <= 1'b0;
      pc_out_ff    <= `CRB_PC_RESET; //RQ9
      carry_out_ff <= 1'b0;
      zero_out_ff  <= 1'b0;
      taken_ff     <= 1'b0;
      bytes_ff     <= 2'h0;
      cycles_ff    <= 3'h0;
    end
    else if (clk_en)
    begin
      // a low enable freezes every register, the done pulse included
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          // issue is looked at only here; one made while busy is dropped
          if (issue && is_branch)
          begin
            // pc_in may move on once the reference is captured
            base_ff      <= base_now;
            short_ff     <= ~long_form;
            bit_low_ff   <= br_bit_low;
            bitsel_ff    <= opcode[`CRB_BITSEL_LSB +: 3]; //RQ8
            addr_ff      <= addr_byte;
            zero_out_ff  <= zero_in; //RQ7
            carry_out_ff <= carry_in;
            if (long_form)
            begin
              disp_ff   <= disp_byte; //RQ6
              bytes_ff  <= `CRB_LONG_BYTES; //RQ8
              cycles_ff <= `CRB_LONG_CYCLES;
              cnt_ff    <= LONG_WAIT;
              state_ff  <= ST_READ;
            end
            else
            begin
              disp_ff   <= {3'h0, opcode[`CRB_DISP5_LSB +: 5]}; //RQ3
              cond_ff   <= short_cond;
              bytes_ff  <= `CRB_SHORT_BYTES; //RQ3
              cycles_ff <= `CRB_SHORT_CYCLES;
              cnt_ff    <= SHORT_WAIT;
              state_ff  <= ST_WAIT;
            end
          end
        end
        ST_READ:
        begin
          // hold the read until the data-space answers
          // no timeout: a data space that never answers stalls the unit
          if (data_valid)
          begin
            tested_ff <= tested_bit;
            cond_ff   <= bit_low_ff ? ~tested_bit : tested_bit; //RQ4 //RQ5
            state_ff  <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (cnt_ff != 3'h0)
            cnt_ff <= cnt_ff - 3'h1;
          else
          begin
            // taken and pc results change only here and stand until the next done; flags, bytes and cycles load at issue, and bit branches load carry again here
            done_ff   <= 1'b1;
            taken_ff  <= cond_ff;
            pc_out_ff <= cond_ff ? target : base_ff; //RQ1 //RQ2 //RQ4 //RQ5
            if (!short_ff)
              carry_out_ff <= tested_ff; //RQ7
            state_ff  <= ST_IDLE;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** bench/crb_branch_props.sv ***
// concurrent checks on the branch unit ports
`timescale 1ns/1ps
module crb_branch_props (
  input wire       clk,
  input wire       reset_n,
  input wire       clk_en,
  input wire       issue,
  input wire [7:0] opcode,
  input wire       carry_in,
  input wire       zero_in,
  input wire       data_valid,
  input wire       busy,
  input wire       is_branch,
  input wire       data_req,
  input wire       done_ff,
  input wire       zero_out_ff,
  input wire       taken_ff,
  input wire [1:0] bytes_ff,
  input wire [2:0] cycles_ff
);
  // a low enable stretches any transfer, so checks stand down meanwhile
  wire go = issue && !busy && is_branch && clk_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || !clk_en);
  sequence s_short; go && !opcode[0]; endsequence
  sequence s_long; go && opcode[0] ##1 data_valid; endsequence
  a_short_len: assert property (s_short |-> ##1 !done_ff ##1 done_ff
    && bytes_ff == 2'h1 && cycles_ff == 3'h2) else $error("short len");
  a_carry_test: assert property (go && opcode[2:0] == 3'h2 |->
    ##2 taken_ff != $past(carry_in, 2)) else $error("carry test");
  a_zero_test: assert property (go && opcode[2:0] == 3'h0 |->
    ##2 taken_ff != $past(zero_in, 2)) else $error("zero test");
  a_zero_kept: assert property (s_short |-> ##2
    zero_out_ff == $past(zero_in, 2)) else $error("zero kept");
  a_long_read: assert property (s_long |-> data_req)
    else $error("no read");
  a_long_len: assert property (s_long |-> !done_ff [*4] ##1 done_ff
    && bytes_ff == 2'h3 && cycles_ff == 3'h5) else $error("long len");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("done width");
  a_go_busy: assert property (go |=> busy)
    else $error("not busy");
endmodule
bind crb_branch_unit crb_branch_props i_props (
  .clk         (clk),
  .reset_n     (reset_n),
  .clk_en      (clk_en),
  .issue       (issue),
  .opcode      (opcode),
  .carry_in    (carry_in),
  .zero_in     (zero_in),
  .data_valid  (data_valid),
  .busy        (busy),
  .is_branch   (is_branch),
  .data_req    (data_req),
  .done_ff     (done_ff),
  .zero_out_ff (zero_out_ff),
  .taken_ff    (taken_ff),
  .bytes_ff    (bytes_ff),
  .cycles_ff   (cycles_ff)
);

// *** bench/test_crb_branch_unit.sv ***
// self-checking bench for the branch unit
`timescale 1ns/1ps
module test_crb_branch_unit;
  localparam [7:0] PAT = 8'h96;
  reg         clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, issue = 1'b0;
  reg         carry_in, zero_in, data_valid, bt;
  reg  [7:0]  opcode, addr_byte, disp_byte, data_value;
  reg  [11:0] pc_in, np;
  wire        busy, is_branch, data_req, done_ff, taken_ff;
  wire        carry_out_ff, zero_out_ff;
  wire [7:0]  data_addr;
  wire [11:0] pc_out_ff;
  wire [1:0]  bytes_ff;
  wire [2:0]  cycles_ff;
  integer     n_fail = 0, n_tests = 0, cyc = 0, k, i;
  crb_branch_unit i_dut (
    .clk          (clk),
    .reset_n      (reset_n),
    .clk_en       (clk_en),
    .issue        (issue),
    .opcode       (opcode),
    .addr_byte    (addr_byte),
    .disp_byte    (disp_byte),
    .pc_in        (pc_in),
    .carry_in     (carry_in),
    .zero_in      (zero_in),
    .data_value   (data_value),
    .data_valid   (data_valid),
    .busy         (busy),
    .is_branch    (is_branch),
    .data_addr    (data_addr),
    .data_req     (data_req),
    .done_ff      (done_ff),
    .pc_out_ff    (pc_out_ff),
    .carry_out_ff (carry_out_ff),
    .zero_out_ff  (zero_out_ff),
    .taken_ff     (taken_ff),
    .bytes_ff     (bytes_ff),
    .cycles_ff    (cycles_ff)
  );
  initial forever #2 clk = ~clk;
  task print_verdict(input integer extra);
    n_fail = n_fail + extra;
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    n_tests = n_tests + 1;
    n_fail = n_fail + (got !== exp);
    if (got !== exp)
      $display("BAD %0t mismatch %h %h", $time, got, exp);
  endtask
  // entered in the done cycle of the last one, so issues run back to back
  task run(input [7:0] op, dp, input [11:0] pc, input c, z, tk, co);
    np = pc + (op[0] ? 12'h003 : 12'h001);
    if (tk)
      np = op[0] ? np + dp - 12'h07e : np + op[7:3] - 12'h00f;
    {opcode, addr_byte, disp_byte, data_value} = {op, ~dp, dp, PAT};
    {pc_in, carry_in, zero_in, data_valid, issue} = {pc, c, z, 2'h3};
    #4 issue = 1'b0;
    chk({busy, is_branch}, 2'h3);
    for (k = 0; done_ff !== 1'b1 && k < 8; k = k + 1)
      #4;
    {data_valid, data_value} = {1'b0, ~PAT};
    chk({k[2:0], bytes_ff, cycles_ff}, op[0] ? 16'h009d : 16'h002a);
    chk({taken_ff, carry_out_ff, zero_out_ff}, {tk, co, z});
    chk(pc_out_ff, np);
    chk(data_addr, addr_byte);
  endtask
  // a low enable refuses issue and stretches a short branch while frozen
  task sc_freeze;
    #4 clk_en = 1'b0;
    {opcode, pc_in, carry_in, zero_in, issue} = {8'h02, 12'h100, 3'h1};
    #8 chk(busy, 1'b0);
    clk_en = 1'b1;
    #4 {issue, clk_en} = 2'h0;
    #8 chk({busy, done_ff}, 2'h2);
    clk_en = 1'b1;
    #4 chk({done_ff, taken_ff, pc_out_ff}, {2'h3, 12'h101 - 12'h00f});
  endtask
  // both flag tests, every flag state, both ends of the short reach
  task sc_short_flags;
    for (i = 0; i < 16; i = i + 1)
      run({i[3] ? 5'h1f : 5'h00, 1'b0, i[2], 1'b0}, 8'h00, 12'h002, i[1],
          i[0], i[2] ? !i[1] : !i[0], i[1]);
  endtask
  // every bit position, both senses, both ends of the long reach
  task sc_bit_test;
    for (i = 0; i < 32; i = i + 1)
    begin
      bt = PAT[i[2:0]];
      run({i[2:0], i[3], 4'h3}, i[4] ? 8'hff : 8'h00, 12'hff8, !bt, i[0],
          i[3] ? bt : !bt, bt);
    end
  endtask
  always @(posedge clk)
    if (cyc == 1000)
      print_verdict(1);
    else
      cyc = cyc + 1;
  initial
  begin
    {carry_in, zero_in, data_valid, opcode, addr_byte} = '0;
    {disp_byte, data_value, pc_in} = '0;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1 sc_short_flags;
    sc_freeze;
    sc_bit_test;
    print_verdict(0);
  end
endmodule
